// ### rtl/blc_ctrl.v
`include "blc_map.vh"
// self-test request responder and initiator control
module blc_ctrl #(
    parameter ALIGN_GAP = 255, // one less than the dwords between align bursts
    parameter FEE_SUPPORTED = 1 // analog loopback implemented
) (
    input wire clk_sys, // system clock
    input wire rst_b, // async reset, active low
    input wire rx_fis_valid, // received frame complete, pulse
    input wire rx_fis_crc_ok, // crc of that frame good
    input wire [31:0] rx_fis_dw0, // frame header dword
    input wire [31:0] rx_fis_dw1, // pattern word 1
    input wire [31:0] rx_fis_dw2, // pattern word 2
    output reg rok_send, // ask link to answer R_OK, pulse
    input wire rok_done, // R_OK sent, pulse
    input wire rx_sync_good, // good SYNC received, pulse
    input wire oob_cominit, // COMINIT seen, async
    input wire oob_comreset, // COMRESET seen, async
    input wire [31:0] rx_dw, // received dword after decode
    input wire rx_dw_k, // byte 0 is a K character
    input wire rx_dw_valid, // received dword strobe
    input wire rx_is_align, // received dword is ALIGN
    input wire rx_scrambled, // link descrambled this dword
    output wire tx_valid, // transmit dword valid
    input wire tx_ready, // transmitter takes dword
    output wire [31:0] tx_dw, // transmit dword
    output wire [3:0] tx_k, // K flags per byte
    output wire tx_scramble, // apply scrambler downstream
    output wire rx_stall, // loopback buffer full
    output reg [2:0] test_mode, // current test mode
    output reg [7:0] pattern_flags, // latched flag byte
    output reg raw_echo_en, // analog path bypasses retiming
    output reg vendor_test, // vendor test active
    input wire init_req, // initiator: send request, pulse
    input wire init_rok, // initiator: R_OK received
    input wire init_ready, // initiator: layers ready
    output reg init_sent, // initiator: request delivered
    output reg init_send_sync, // initiator: send SYNC idle
    output reg init_stream_en // initiator: layers set for stream
);
    localparam RS_IDLE = 2'd0;
    localparam RS_ROK = 2'd1;
    localparam RS_SYNC = 2'd2;
    localparam RS_TEST = 2'd3;
    localparam IS_IDLE = 2'd0;
    localparam IS_WAIT = 2'd1;
    localparam IS_SYNC = 2'd2;
    localparam IS_RUN = 2'd3;

    reg [1:0] rstate;
    reg [1:0] istate;
    reg [31:0] pat1;
    reg [31:0] pat2;
    reg pat_sel;
    reg [8:0] gap_cnt;
    reg [1:0] al_cnt;
    reg [1:0] drop_cnt;
    reg ci_s1, ci_s2, cr_s1, cr_s2;
    wire oob_hit = ci_s2 | cr_s2;

    // flag extraction used by entry decode
    function flag;
        input [31:0] dw;
        input integer pos;
        begin
            flag = dw[pos];
        end
    endfunction

    // decode flag byte into a mode, vendor wins over all
    function [2:0] mode_of;
        input [31:0] dw;
        begin
            if (flag(dw, `BLC_BIT_V)) mode_of = `BLC_MODE_VEN;
            else if (flag(dw, `BLC_BIT_T)) mode_of = `BLC_MODE_TX;
            else if (flag(dw, `BLC_BIT_L)) mode_of = `BLC_MODE_RET;
            else if (flag(dw, `BLC_BIT_F) && FEE_SUPPORTED != 0) mode_of = `BLC_MODE_FEE;
            else mode_of = `BLC_MODE_IDLE;
        end
    endfunction

    // out-of-band pins are asynchronous, two flops first
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ci_s1 <= 1'b0;
            ci_s2 <= 1'b0;
            cr_s1 <= 1'b0;
            cr_s2 <= 1'b0;
        end else begin
            ci_s1 <= oob_cominit;
            ci_s2 <= ci_s1;
            cr_s1 <= oob_comreset;
            cr_s2 <= cr_s1;
        end
    end

    wire is_req = rx_fis_valid && rx_fis_crc_ok && rx_fis_dw0[7:0] == `BLC_FIS_TYPE;

    // responder: frame, R_OK, SYNC, then test
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstate <= RS_IDLE;
            rok_send <= 1'b0;
            test_mode <= `BLC_MODE_IDLE;
            pattern_flags <= 8'h00;
            pat1 <= 32'h00000000;
            pat2 <= 32'h00000000;
            raw_echo_en <= 1'b0;
            vendor_test <= 1'b0;
        end else begin
            rok_send <= 1'b0;
            if (oob_hit) begin
                rstate <= RS_IDLE;
                test_mode <= `BLC_MODE_IDLE;
                raw_echo_en <= 1'b0;
                vendor_test <= 1'b0;
            end else begin
                case (rstate)
                    RS_IDLE: begin
                        if (is_req) begin
                            pattern_flags <= rx_fis_dw0[`BLC_PAT_HI:`BLC_PAT_LO];
                            pat1 <= rx_fis_dw1;
                            pat2 <= rx_fis_dw2;
                            rok_send <= 1'b1;
                            rstate <= RS_ROK;
                        end
                    end
                    RS_ROK: begin
                        if (rok_done) rstate <= RS_SYNC;
                    end
                    RS_SYNC: begin
                        if (rx_sync_good) begin
                            rstate <= RS_TEST;
                            test_mode <= mode_of({8'h00, pattern_flags, 16'h0000});
                            raw_echo_en <= (mode_of({8'h00, pattern_flags, 16'h0000})
                                == `BLC_MODE_FEE);
                            vendor_test <= pattern_flags[`BLC_BIT_V - `BLC_PAT_LO];
                        end
                    end
                    RS_TEST: begin
                        rstate <= RS_TEST;
                    end
                    default: rstate <= RS_IDLE;
                endcase
            end
        end
    end

    // initiator: request counts as sent only on R_OK, then SYNC until ready
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            istate <= IS_IDLE;
            init_sent <= 1'b0;
            init_send_sync <= 1'b0;
            init_stream_en <= 1'b0;
        end else if (oob_hit) begin
            istate <= IS_IDLE;
            init_sent <= 1'b0;
            init_send_sync <= 1'b0;
            init_stream_en <= 1'b0;
        end else begin
            case (istate)
                IS_IDLE: if (init_req) istate <= IS_WAIT;
                IS_WAIT: begin
                    if (init_rok) begin
                        init_sent <= 1'b1;
                        init_send_sync <= 1'b1;
                        init_stream_en <= 1'b1;
                        istate <= IS_SYNC;
                    end
                end
                IS_SYNC: begin
                    if (init_ready) begin
                        init_send_sync <= 1'b0;
                        istate <= IS_RUN;
                    end
                end
                IS_RUN: istate <= IS_RUN;
                default: istate <= IS_IDLE;
            endcase
        end
    end

    wire looping = rstate == RS_TEST &&
        (test_mode == `BLC_MODE_RET || test_mode == `BLC_MODE_FEE);
    wire tx_mode = rstate == RS_TEST && test_mode == `BLC_MODE_TX;
    wire want_align = gap_cnt == 9'd0;
    wire omit_align = pattern_flags[`BLC_BIT_A - `BLC_PAT_LO];

    // drop at most two received ALIGNs per interval, echo all else unchanged
    wire drop_al = looping && rx_is_align && drop_cnt != `BLC_ALIGN_BURST;
    wire lb_in_valid = looping && rx_dw_valid && !drop_al;
    // the K flag rides with the word so that a looped primitive stays a primitive
    wire [35:0] lb_in = {2'b00, rx_dw_k, rx_scrambled, rx_dw};
    wire lb_in_ready;
    wire lb_out_valid;
    wire [35:0] lb_out;
    wire [31:0] smask;
    wire ins_al = al_cnt != 2'd0;
    wire pat_go = tx_mode && !ins_al && tx_ready;
    wire lb_pop = looping && !ins_al && tx_ready;

    blc_buf2 #(.W(36)) u_buf (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .in_valid(lb_in_valid),
        .in_ready(lb_in_ready),
        .in_data(lb_in),
        .out_valid(lb_out_valid),
        .out_ready(lb_pop),
        .out_data(lb_out)
    );

    // pattern-mode scramble mask; loopback rescramble is applied downstream
    blc_scram u_scr (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .restart(!tx_mode),
        .advance(pat_go),
        .mask(smask)
    );

    assign rx_stall = !lb_in_ready;

    // ALIGN timing: bursts of two every interval except far-end transmit with omit flag set, drop window re-armed
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt <= `BLC_ALIGN_GAP;
            al_cnt <= 2'd0;
            drop_cnt <= 2'd0;
            pat_sel <= 1'b0;
        end else begin
            if (rstate != RS_TEST) begin
                gap_cnt <= ALIGN_GAP[8:0];
                al_cnt <= 2'd0;
                drop_cnt <= 2'd0;
                pat_sel <= 1'b0;
            end else begin
                if (drop_al) drop_cnt <= drop_cnt + 2'd1;
                if (tx_ready) begin
                    if (ins_al) begin
                        al_cnt <= al_cnt - 2'd1;
                    end else begin
                        // the word taken just before a burst is a pattern word too
                        if (tx_mode) pat_sel <= ~pat_sel;
                        if (want_align && !(tx_mode && omit_align)) begin
                            al_cnt <= `BLC_ALIGN_BURST;
                            gap_cnt <= ALIGN_GAP[8:0];
                            drop_cnt <= 2'd0;
                        end else begin
                            gap_cnt <= want_align ? ALIGN_GAP[8:0] : gap_cnt - 9'd1;
                        end
                    end
                end
            end
        end
    end

    // transmit select: ALIGN burst, echoed data, or pattern words
    wire [31:0] pat = pat_sel ? pat2 : pat1;
    wire raw_mix = pattern_flags[`BLC_BIT_S - `BLC_PAT_LO];
    wire prim = pattern_flags[`BLC_BIT_P - `BLC_PAT_LO];
    assign tx_valid = rstate == RS_TEST && !vendor_test &&
        (ins_al || tx_mode || lb_out_valid);
    assign tx_dw = ins_al ? `BLC_ALIGN_DW :
        tx_mode ? ((raw_mix || prim) ? pat : pat ^ smask) : lb_out[31:0];
    assign tx_k = ins_al ? `BLC_KMASK_B0 :
        (tx_mode && prim) ? `BLC_KMASK_B0 :
        looping ? {3'b000, lb_out[33]} : `BLC_KMASK_NONE;
    assign tx_scramble = looping && !ins_al && lb_out[32] && !raw_echo_en;
endmodule // blc_ctrl

// ### rtl/blc_map.vh
// Functional notes
// - self-test frame: type 58h, pattern byte with mode flags, two 32-bit pattern words.
// - host or device may send the request; sending and receiving logic are symmetric.
// - a sent request counts as delivered only after the partner returns R_OK.
// - after R_OK the sender keeps sending SYNC until ready for the test.
// - once told of delivery, the sender readies its layers for test streaming.
// - responder enters test only after a good-CRC frame, R_OK sent, then a good SYNC.
// - COMINIT or COMRESET received during test mode forces exit from test mode.
// - analog loopback returns raw received data without retiming, when supported.
// - retimed loopback retimes received data and sends the retimed stream back.
// - retimed responder may drop up to two ALIGNs and insert ALIGNs in legal places.
// - after a four-ALIGN burst, every returned ALIGN burst is at least two long.
// - a descrambling responder rescrambles with the same sequence, data unchanged.
// - loopback returns all data unchanged, acting only on out-of-band and ALIGN.
// - far-end transmit mode sends the two pattern words; they matter only there.
// - primitive flag makes byte 0 of both pattern words K characters, e.g. BCh.
// - far-end transmit sends no ALIGN when omit flag is 1, normal ALIGNs when 0.
// - far-end transmit with raw-unmixed flag sends unscrambled but legal characters.
// - maker-unique flag enters vendor test mode and ignores every other flag.
`ifndef BLC_MAP_VH
`define BLC_MAP_VH
`define BLC_FIS_TYPE 8'h58
`define BLC_PAT_LO 16
`define BLC_PAT_HI 23
`define BLC_BIT_V 16
`define BLC_BIT_R 17
`define BLC_BIT_P 18
`define BLC_BIT_F 19
`define BLC_BIT_L 20
`define BLC_BIT_S 21
`define BLC_BIT_A 22
`define BLC_BIT_T 23
`define BLC_ALIGN_GAP 9'd255
`define BLC_ALIGN_BURST 2'd2
`define BLC_ALIGN_DW 32'h7b4a4abc
`define BLC_SYNC_DW 32'hb5b5957c
`define BLC_KMASK_NONE 4'h0
`define BLC_KMASK_B0 4'h1
`define BLC_MODE_IDLE 3'h0
`define BLC_MODE_FEE 3'h1
`define BLC_MODE_RET 3'h2
`define BLC_MODE_TX 3'h3
`define BLC_MODE_VEN 3'h4
`endif

// ### rtl/blc_buf2.v
// two-entry skid buffer, flip-flop storage addressed by index
module blc_buf2 #(
    parameter W = 36
) (
    input wire clk_sys, // system clock
    input wire rst_b, // async reset, active low
    input wire in_valid, // write side valid
    output wire in_ready, // write side ready
    input wire [W-1:0] in_data, // write data
    output wire out_valid, // read side valid
    input wire out_ready, // read side ready
    output wire [W-1:0] out_data // read data, from flip-flops
);
    reg [W-1:0] mem [0:1];
    reg wp;
    reg rp;
    reg [1:0] cnt;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // full at two, empty at zero
    assign in_ready = (cnt != 2'd2);
    assign out_valid = (cnt != 2'd0);
    assign out_data = mem[rp];

    // pointer and count update
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'd0;
        end else begin
            if (push) wp <= ~wp;
            if (pop) rp <= ~rp;
            cnt <= cnt + {1'b0, push} - {1'b0, pop};
        end
    end

    // storage write
    always @(posedge clk_sys) begin
        if (push) mem[wp] <= in_data;
    end
endmodule // blc_buf2

// ### rtl/blc_scram.v
// link scrambler, lfsr x^16+x^15+x^13+x^4+1, one dword per advance
module blc_scram (
    input wire clk_sys, // system clock
    input wire rst_b, // async reset, active low
    input wire restart, // reseed the lfsr
    input wire advance, // step one dword
    output wire [31:0] mask // current scramble mask
);
    reg [15:0] lfsr;
    reg [31:0] m;
    reg [15:0] s;
    integer i;

    // derive 32 mask bits and next state
    always @* begin
        s = lfsr;
        m = 32'h00000000;
        for (i = 0; i < 32; i = i + 1) begin
            m[i] = s[15];
            s = {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
        end
    end
    assign mask = m;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) lfsr <= 16'hffff;
        else if (restart) lfsr <= 16'hffff;
        else if (advance) lfsr <= s;
    end
endmodule // blc_scram

// ### verif/blc_ctrl_monitor.sv
`include "blc_map.vh"
// concurrent checks on the control block's ports
module blc_ctrl_monitor (
    input wire clk_sys, // system clock
    input wire rst_b, // async reset, active low
    input wire rx_fis_valid, // frame done
    input wire rx_fis_crc_ok, // frame crc good
    input wire [31:0] rx_fis_dw0, // frame header
    input wire rok_send, // R_OK request
    input wire rx_sync_good, // good SYNC seen
    input wire oob_cominit, // COMINIT pin
    input wire oob_comreset, // COMRESET pin
    input wire tx_valid, // transmit valid
    input wire [2:0] test_mode, // current mode
    input wire vendor_test, // vendor mode flag
    input wire init_rok, // initiator R_OK
    input wire init_ready, // initiator ready
    input wire init_sent, // request delivered
    input wire init_send_sync // SYNC idle request
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // frame acceptance and answer timing, then mode entry, out-of-band exit, vendor and initiator checks
    rok_answer_a: assert property (rx_fis_valid && rx_fis_crc_ok && rx_fis_dw0[7:0] == `BLC_FIS_TYPE && test_mode == `BLC_MODE_IDLE |=> rok_send) else $error("no R_OK after good frame");
    rok_pulse_a: assert property (rok_send |=> !rok_send) else $error("R_OK request too long");
    bad_crc_a: assert property (rx_fis_valid && !rx_fis_crc_ok |=> !rok_send) else $error("R_OK after bad crc");
    mode_entry_a: assert property (test_mode != `BLC_MODE_IDLE && $past(test_mode) == `BLC_MODE_IDLE |-> $past(rx_sync_good)) else $error("test entered without SYNC");
    oob_exit_a: assert property (oob_cominit || oob_comreset |-> ##[1:5] test_mode == `BLC_MODE_IDLE) else $error("no exit on out-of-band");
    vendor_quiet_a: assert property (vendor_test |-> !tx_valid) else $error("transmit in vendor mode");
    vendor_mode_a: assert property (test_mode == `BLC_MODE_VEN |-> vendor_test) else $error("vendor flag missing");
    sent_cause_a: assert property ($rose(init_sent) |-> $past(init_rok) && init_send_sync) else $error("delivered without R_OK");
    sync_stop_a: assert property (init_send_sync && init_ready |=> !init_send_sync) else $error("SYNC idle held when ready");
endmodule // blc_ctrl_monitor

// ### verif/blc_peer.sv
// link peer: answers R_OK requests, then sends a good SYNC; stalls on demand
module blc_peer (
    input wire clk_sys, // system clock
    input wire rst_b, // async reset, active low
    input wire rok_send, // R_OK request from block
    input wire hold, // bench asks for a stall
    output logic rok_done, // R_OK sent, pulse
    output logic rx_sync_good, // good SYNC, pulse
    output wire tx_ready // takes transmit dword
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt;
    // frame, then R_OK, then SYNC, in that order
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 3'h0;
            rok_done <= 1'b0;
            rx_sync_good <= 1'b0;
        end else begin
            cnt <= rok_send ? 3'h1 : (cnt == 3'h6 || cnt == 3'h0) ? 3'h0 : cnt + 3'h1;
            rok_done <= (cnt == 3'h2);
            rx_sync_good <= (cnt == 3'h5);
        end
    end
    assign tx_ready = ~hold; // stall leaves words in the block's buffer
endmodule // blc_peer

// ### verif/tb_bist_loopback_control.sv
`include "blc_map.vh"
module tb_bist_loopback_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, rst_b = 0, rx_fis_valid = 0, rx_fis_crc_ok = 0, rx_dw_valid = 0, hold = 0;
    logic oob_cominit = 0, oob_comreset = 0, init_req = 0, init_rok = 0, init_ready = 0;
    logic rx_dw_k = 0, rx_is_align = 0, rx_scrambled = 0;
    logic [31:0] rx_fis_dw0 = 0, rx_fis_dw1 = 0, rx_fis_dw2 = 0, rx_dw = 0, tx_dw;
    logic rok_send, rok_done, rx_sync_good, tx_valid, tx_ready, tx_scramble, rx_stall;
    logic raw_echo_en, vendor_test, init_sent, init_send_sync, init_stream_en;
    logic [3:0] tx_k;
    logic [2:0] test_mode;
    logic [7:0] pattern_flags;
    int num_errors = 0, checks = 0;
    blc_ctrl #(.ALIGN_GAP(15), .FEE_SUPPORTED(1)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .rx_fis_valid(rx_fis_valid), .rx_fis_crc_ok(rx_fis_crc_ok), .rx_fis_dw0(rx_fis_dw0),
        .rx_fis_dw1(rx_fis_dw1), .rx_fis_dw2(rx_fis_dw2), .rok_send(rok_send), .rok_done(rok_done),
        .rx_sync_good(rx_sync_good), .oob_cominit(oob_cominit), .oob_comreset(oob_comreset),
        .rx_dw(rx_dw), .rx_dw_k(rx_dw_k), .rx_dw_valid(rx_dw_valid), .rx_is_align(rx_is_align),
        .rx_scrambled(rx_scrambled), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_dw(tx_dw),
        .tx_k(tx_k),
        .tx_scramble(tx_scramble), .rx_stall(rx_stall), .test_mode(test_mode),
        .pattern_flags(pattern_flags), .raw_echo_en(raw_echo_en), .vendor_test(vendor_test),
        .init_req(init_req), .init_rok(init_rok), .init_ready(init_ready), .init_sent(init_sent),
        .init_send_sync(init_send_sync), .init_stream_en(init_stream_en));
    blc_peer i_peer (.clk_sys(clk_sys), .rst_b(rst_b), .rok_send(rok_send), .hold(hold),
        .rok_done(rok_done), .rx_sync_good(rx_sync_good), .tx_ready(tx_ready));
    // clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task tick;
        @(posedge clk_sys);
        #1;
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (exp !== got) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one received frame, driven for a single cycle
    task frame(input logic [7:0] flags, input logic ok, input logic [7:0] ftype);
        rx_fis_dw0 = {8'h00, flags, 8'h00, ftype};
        rx_fis_dw1 = 32'h1234_56bc;
        rx_fis_dw2 = 32'h8765_43bc;
        rx_fis_crc_ok = ok;
        rx_fis_valid = 1;
        tick;
        rx_fis_valid = 0;
    endtask
    task enter(input logic [7:0] flags);
        int i;
        frame(flags, 1'b1, `BLC_FIS_TYPE);
        chk("rok_send", 1, rok_send);
        tick;
        for (i = 0; i < 20 && test_mode === `BLC_MODE_IDLE; i++) tick;
        if (i == 20) begin
            num_errors++;
            $display("[ERR] test_mode entry expected not idle seen %h", test_mode);
            conclude();
        end
    endtask
    task leave(input logic by_reset);
        int i;
        if (by_reset) oob_comreset = 1;
        else oob_cominit = 1;
        tick;
        tick;
        oob_comreset = 0;
        oob_cominit = 0;
        for (i = 0; i < 8 && test_mode !== `BLC_MODE_IDLE; i++) tick;
        chk("test_mode exit", `BLC_MODE_IDLE, test_mode);
        // let the pin synchroniser drain before the next frame
        repeat (3) tick;
    endtask
    task t_refuse;
        int i;
        frame(8'h10, 1'b0, `BLC_FIS_TYPE);
        chk("rok_send bad crc", 0, rok_send);
        tick;
        frame(8'h10, 1'b1, 8'h46);
        for (i = 0; i < 12; i++) begin
            chk("rok_send refused", 0, rok_send);
            tick;
        end
        chk("test_mode refused", `BLC_MODE_IDLE, test_mode);
        $display("test refuse done");
    endtask
    task t_modes;
        logic [7:0] fl[4] = '{8'h08, 8'h10, 8'h80, 8'h81};
        logic [2:0] md[4] = '{`BLC_MODE_FEE, `BLC_MODE_RET, `BLC_MODE_TX, `BLC_MODE_VEN};
        int i;
        for (i = 0; i < 4; i++) begin
            enter(fl[i]);
            chk("test_mode", md[i], test_mode);
            chk("pattern_flags", fl[i], pattern_flags);
            chk("raw_echo_en", i == 0, raw_echo_en);
            chk("vendor_test", i == 3, vendor_test);
            if (i == 3) chk("tx_valid vendor", 0, tx_valid);
            leave(i[0]);
        end
        $display("test modes done");
    endtask
    // retimed echo through a stalled buffer, returned words unchanged
    task t_echo;
        logic [33:0] q[$];
        logic [33:0] e;
        int i;
        enter(8'h10);
        hold = 1;
        rx_dw = `BLC_ALIGN_DW; // extra ALIGN sent as one burst
        rx_is_align = 1;
        rx_dw_valid = 1;
        tick;
        rx_is_align = 0;
        for (i = 0; i < 8 && rx_stall !== 1'b1; i++) begin
            rx_dw = i[0] ? `BLC_SYNC_DW : 32'h5a00_0010 + i;
            rx_dw_k = i[0];
            rx_scrambled = ~i[0];
            q.push_back({rx_dw_k, rx_scrambled, rx_dw});
            tick;
        end
        chk("align dropped", 2, i);
        rx_dw_valid = 0;
        rx_dw_k = 0;
        rx_scrambled = 0;
        tick;
        chk("rx_stall", 1, rx_stall);
        hold = 0;
        for (i = 0; i < 40 && q.size() > 0; i++) begin
            if (tx_valid === 1'b1 && tx_dw !== `BLC_ALIGN_DW) begin
                e = q.pop_front();
                chk("echo", e[31:0], tx_dw);
                chk("echo k", e[33], tx_k[0]);
                chk("echo scramble", e[32], tx_scramble);
            end
            tick;
        end
        chk("echo left", 0, q.size());
        leave(0);
        $display("test echo done");
    endtask
    // far-end transmit with its modifier flags
    task t_fet(input logic [7:0] flags);
        int i, k, na, b;
        logic [15:0] lf;
        logic [31:0] m, p;
        k = 0;
        na = 0;
        lf = 16'hffff;
        m = 0;
        enter(flags);
        for (i = 0; i < 48; i++) begin
            if (tx_valid === 1'b1 && tx_dw === `BLC_ALIGN_DW) na++;
            else if (tx_valid === 1'b1) begin
                // reference scrambler x^16+x^15+x^13+x^4+1, seed all ones, one step per word
                for (b = 0; b < 32; b++) begin
                    m[b] = lf[15];
                    lf = {lf[14:0], lf[15] ^ lf[14] ^ lf[12] ^ lf[3]};
                end
                p = k[0] ? rx_fis_dw2 : rx_fis_dw1;
                if (!flags[5] && !flags[2]) p = p ^ m;
                chk("pattern", p, tx_dw);
                chk("tx_k", flags[2] ? `BLC_KMASK_B0 : `BLC_KMASK_NONE, tx_k);
                if (flags[5]) chk("tx_scramble", 0, tx_scramble);
                k++;
            end
            tick;
        end
        chk("align seen", !flags[6], na > 0);
        leave(1);
        $display("test far-end %h done", flags);
    endtask
    task t_init;
        init_req = 1;
        tick;
        init_req = 0;
        repeat (3) tick;
        chk("init_sent early", 0, init_sent);
        init_rok = 1;
        tick;
        init_rok = 0;
        chk("init_sent", 1, init_sent);
        chk("init_send_sync", 1, init_send_sync);
        chk("init_stream_en", 1, init_stream_en);
        init_ready = 1;
        tick;
        tick;
        chk("init_send_sync off", 0, init_send_sync);
        $display("test initiator done");
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        #1;
        rst_b = 1;
        tick;
        chk("reset mode", `BLC_MODE_IDLE, test_mode);
        t_refuse();
        t_modes();
        t_echo();
        t_fet(8'h80);
        t_fet(8'hc4);
        t_fet(8'ha0);
        t_init();
        conclude();
    end
endmodule // tb_bist_loopback_control
bind blc_ctrl blc_ctrl_monitor i_mon (.clk_sys(clk_sys), .rst_b(rst_b),
    .rx_fis_valid(rx_fis_valid), .rx_fis_crc_ok(rx_fis_crc_ok), .rx_fis_dw0(rx_fis_dw0),
    .rok_send(rok_send), .rx_sync_good(rx_sync_good), .oob_cominit(oob_cominit),
    .oob_comreset(oob_comreset), .tx_valid(tx_valid), .test_mode(test_mode),
    .vendor_test(vendor_test), .init_rok(init_rok), .init_ready(init_ready),
    .init_sent(init_sent), .init_send_sync(init_send_sync));
